// file: hw/shared_irq_logic.v
// Purpose: Eight-level prioritised request logic with shared-level arming and NMI forming.
// Assumes: Board request inputs are active high; expansion lines are active low, pulled up.
// Notes:   Reading the vector register acknowledges; writing the EOI register ends service.
`timescale 1ns/100ps
`include "shared_irq_map.vh"

module shared_irq_logic #(
	parameter ADDR_W = 8
) (
	// Clock and reset
	input  wire              aclk,
	input  wire              aresetn,
	// AXI4-Lite write address and data
	input  wire [ADDR_W-1:0] awaddr,
	input  wire              awvalid,
	output reg               awready,
	input  wire [31:0]       wdata,
	input  wire [3:0]        wstrb,
	input  wire              wvalid,
	output reg               wready,
	// AXI4-Lite write response
	output reg  [1:0]        bresp,
	output reg               bvalid,
	input  wire              bready,
	// AXI4-Lite read
	input  wire [ADDR_W-1:0] araddr,
	input  wire              arvalid,
	output reg               arready,
	output reg  [31:0]       rdata,
	output reg  [1:0]        rresp,
	output reg               rvalid,
	input  wire              rready,
	// System board request sources, active high
	input  wire              timer0_out,
	input  wire              keyboard_req,
	input  wire              pointing_req,
	input  wire              video_req,
	input  wire              serial_req,
	input  wire              parallel_req,
	// Expansion bus shared request lines, levels two to seven, active low
	input  wire [7:2]        bus_irq_n,
	// NMI sources, active low
	input  wire              copro_int_n,
	input  wire              parity_n,
	input  wire              channel_check_n,
	// Processor side
	output reg               int_req_q,
	output reg  [2:0]        int_vec_q,
	output reg               nmi_q,
	// Global rearm strobes to the expansion bus, one per shared level
	output reg  [7:2]        rearm_q
);
	// ======================================================================
	// Request lines: board sources pull the line low while they request
	wire [7:0] line_n;
	wire [7:0] raise;
	assign line_n[0] = ~timer0_out;
	assign line_n[1] = ~(keyboard_req | pointing_req);
	assign line_n[2] = bus_irq_n[2] & ~video_req;
	assign line_n[3] = bus_irq_n[3];
	assign line_n[4] = bus_irq_n[4] & ~serial_req;
	assign line_n[5] = bus_irq_n[5];
	assign line_n[6] = bus_irq_n[6];
	assign line_n[7] = bus_irq_n[7] & ~parallel_req;

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_level
			line_edge_arm u_arm (
				.aclk    (aclk),
				.aresetn (aresetn),
				.line_n  (line_n[gi]),
				.raise_q (raise[gi])
			);
		end
	endgenerate

	// ======================================================================
	// Fixed priority: lowest index wins
	function [3:0] top_of;
		input [7:0] v;
		integer k;
		begin
			top_of = 4'h0;
			for (k = 7; k >= 0; k = k - 1) begin
				if (v[k]) begin
					top_of = {1'b1, k[2:0]};
				end
			end
		end
	endfunction

	reg  [7:0] pend_q;
	reg  [7:0] mask_q;
	reg  [7:0] isr_q;
	reg  [7:0] sysctl_q;
	wire [3:0] cand = top_of(pend_q & ~mask_q);
	wire [3:0] serv = top_of(isr_q);
	wire       cand_ok = cand[3] && (!serv[3] || cand[2:0] < serv[2:0]);

	// ======================================================================
	// NMI sources through two flip-flops
	reg [2:0] nmi_s1_q;
	reg [2:0] nmi_s2_q;
	wire copro_act = ~nmi_s2_q[2];
	wire par_act   = ~nmi_s2_q[1];
	wire chk_act   = ~nmi_s2_q[0];

	// ======================================================================
	// Bus slave
	reg [ADDR_W-1:0] aw_addr_q;
	reg [31:0]       w_data_q;
	reg              aw_have_q;
	reg              w_have_q;
	reg [3:0]        wstrb_q;
	wire             do_write = aw_have_q && w_have_q && !bvalid;
	wire             wr_hit   = aw_addr_q == `OFS_MASK || aw_addr_q == `OFS_EOI ||
	                            aw_addr_q == `OFS_SYSCTL || aw_addr_q == `OFS_REARM;
	wire             do_read  = arvalid && arready;
	wire             ack_read = do_read && araddr == `OFS_VECTOR && cand_ok;
	wire             eoi_wr   = do_write && aw_addr_q == `OFS_EOI && w_data_q[0];
	wire [2:0]       rearm_lvl = w_data_q[2:0];
	wire             wdata_ok_rearm = rearm_lvl >= `REARM_LVL_LO && rearm_lvl <= `REARM_LVL_HI;
	wire             rearm_wr = do_write && aw_addr_q == `OFS_REARM && wdata_ok_rearm;

	reg [31:0] rd_d;
	reg        rd_hit;
	always @* begin
		rd_d   = 32'h0000_0000;
		rd_hit = 1'b1;
		case (araddr)
			`OFS_PENDING: rd_d[7:0] = pend_q;
			`OFS_MASK:    rd_d[7:0] = mask_q;
			`OFS_VECTOR:  rd_d[7:0] = {cand_ok, 4'h0, cand[2:0]};
			`OFS_EOI:     rd_d[7:0] = isr_q;
			`OFS_SYSCTL:  rd_d[7:0] = sysctl_q;
			`OFS_NMISTAT: rd_d[7:0] = {par_act, chk_act, copro_act, 5'h00};
			`OFS_REARM:   rd_d[11:0] = `REARM_BASE;
			default:      rd_hit = 1'b0;
		endcase
	end

	// ======================================================================
	// Pending, in-service and control state
	integer i;
	always @(posedge aclk) begin
		if (!aresetn) begin
			pend_q   <= 8'h00;
			isr_q    <= 8'h00;
			mask_q   <= `MASK_RESET;
			sysctl_q <= `SYSCTL_RESET;
			rearm_q  <= 6'h00;
		end else begin
			for (i = 0; i < 8; i = i + 1) begin
				// A raise in the acknowledge cycle keeps the level pending.
				if (raise[i]) begin
					pend_q[i] <= 1'b1;
				end else if (ack_read && cand[2:0] == i[2:0]) begin
					pend_q[i] <= 1'b0;
				end
				if (ack_read && cand[2:0] == i[2:0]) begin
					isr_q[i] <= 1'b1;
				end else if (eoi_wr && serv[3] && serv[2:0] == i[2:0]) begin
					isr_q[i] <= 1'b0;
				end
			end
			if (do_write && aw_addr_q == `OFS_MASK && wstrb_q[0]) begin
				mask_q <= w_data_q[7:0];
			end
			if (do_write && aw_addr_q == `OFS_SYSCTL && wstrb_q[0]) begin
				sysctl_q <= w_data_q[7:0];
			end
			rearm_q <= 6'h00;
			for (i = 2; i < 8; i = i + 1) begin
				if (rearm_wr && rearm_lvl == i[2:0]) begin
					rearm_q[i] <= 1'b1;
				end
			end
		end
	end

	// ======================================================================
	// Processor outputs and NMI
	always @(posedge aclk) begin
		if (!aresetn) begin
			nmi_s1_q  <= 3'h7;
			nmi_s2_q  <= 3'h7;
			nmi_q     <= 1'b0;
			int_req_q <= 1'b0;
			int_vec_q <= 3'h0;
		end else begin
			nmi_s1_q  <= {copro_int_n, parity_n, channel_check_n};
			nmi_s2_q  <= nmi_s1_q;
			nmi_q     <= copro_act |
			             (par_act & ~sysctl_q[`SYSCTL_PAR_BLOCK]) |
			             (chk_act & ~sysctl_q[`SYSCTL_CHK_BLOCK]);
			int_req_q <= cand_ok;
			int_vec_q <= cand[2:0];
		end
	end

	// ======================================================================
	// AXI4-Lite handshakes; address and data are taken in either order.
	always @(posedge aclk) begin
		if (!aresetn) begin
			awready   <= 1'b1;
			wready    <= 1'b1;
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			aw_addr_q <= {ADDR_W{1'b0}};
			w_data_q  <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
			bvalid    <= 1'b0;
			bresp     <= `RESP_OKAY;
			arready   <= 1'b1;
			rvalid    <= 1'b0;
			rdata     <= 32'h0000_0000;
			rresp     <= `RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				awready   <= 1'b0;
				aw_have_q <= 1'b1;
				aw_addr_q <= awaddr;
			end
			if (wvalid && wready) begin
				wready   <= 1'b0;
				w_have_q <= 1'b1;
				w_data_q <= wdata;
				wstrb_q  <= wstrb;
			end
			if (do_write) begin
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
				bvalid    <= 1'b1;
				bresp     <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
			if (do_read) begin
				arready <= 1'b0;
				rvalid  <= 1'b1;
				rdata   <= rd_d;
				rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (rvalid && rready) begin
				rvalid  <= 1'b0;
				arready <= 1'b1;
			end
		end
	end
endmodule

// file: pkg/shared_irq_map.vh
// Purpose: Offsets, field positions, reset values and codes of the shared request logic.
// Assumes: Included by bare name; definitions only.
// Notes:   Byte addresses on a 32-bit AXI4-Lite register bus.
`ifndef SHARED_IRQ_MAP_VH
`define SHARED_IRQ_MAP_VH

// ==========================================================================
// Register offsets
`define OFS_PENDING   8'h00
`define OFS_MASK      8'h04
`define OFS_VECTOR    8'h08
`define OFS_EOI       8'h0c
`define OFS_SYSCTL    8'h10
`define OFS_NMISTAT   8'h14
`define OFS_REARM     8'h18

// ==========================================================================
// Field positions and reset values
`define MASK_RESET         8'hff
`define SYSCTL_RESET       8'h00
`define SYSCTL_CHK_BLOCK   5
`define SYSCTL_PAR_BLOCK   4
`define NMISTAT_PARITY     7
`define NMISTAT_CHK        6
`define NMISTAT_COPRO      5
`define VECTOR_VALID       7

// ==========================================================================
// Global rearm addresses: base plus level digit, levels two to seven
`define REARM_BASE    12'h2f0
`define REARM_LVL_LO  3'h2
`define REARM_LVL_HI  3'h7

// ==========================================================================
// Bus answers
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// file: hw/line_edge_arm.v
// Purpose: One request line: synchronise, arm on the falling edge, raise on the rising edge.
// Assumes: Line is active low, released high; may be asynchronous to aclk.
// Notes:   A pulse must be low for at least one aclk period to be seen.
`timescale 1ns/100ps
module line_edge_arm (
	// Clock and reset
	input  wire aclk,
	input  wire aresetn,
	// Request line, active low
	input  wire line_n,
	// One-cycle pulse at the trailing edge of an armed pulse
	output reg  raise_q
);
	reg sync1_q;
	reg sync2_q;
	reg prev_q;
	reg armed_q;

	always @(posedge aclk) begin
		if (!aresetn) begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
			prev_q  <= 1'b1;
			armed_q <= 1'b0;
			raise_q <= 1'b0;
		end else begin
			sync1_q <= line_n;
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
			raise_q <= 1'b0;
			if (prev_q && !sync2_q) begin
				armed_q <= 1'b1;
			end else if (!prev_q && sync2_q && armed_q) begin
				armed_q <= 1'b0;
				raise_q <= 1'b1;
			end
		end
	end
endmodule

// file: tb/shared_irq_logic_assertions.sv
// Purpose: Port-level checks of NMI forming, rearm strobes and register bus answers.
// Assumes: One aclk domain with a synchronous active-low reset.
// Notes:   System control block bits are not visible here, so NMI checks use cases no block bit can alter.
`timescale 1ns/100ps
`include "shared_irq_map.vh"
// ==========================================================================
// Checker
module shared_irq_logic_assertions (
	// Clock and reset
	input wire       aclk,
	input wire       aresetn,
	// Register bus
	input wire       awready,
	input wire       wready,
	input wire       arready,
	input wire       bvalid,
	input wire [1:0] bresp,
	input wire       rvalid,
	// NMI sources and outputs
	input wire       copro_int_n,
	input wire       parity_n,
	input wire       channel_check_n,
	input wire       nmi_q,
	input wire [7:2] rearm_q
);
	// The synchronisers restart at reset, so NMI checks wait until they have refilled.
	reg [2:0] warm_q;
	always @(posedge aclk) begin
		if (!aresetn) warm_q <= 3'h0;
		else if (warm_q != 3'h7) warm_q <= warm_q + 3'h1;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_nmi_copro; (warm_q == 3'h7 && !copro_int_n) [*5] |-> nmi_q; endproperty
	a_nmi_copro: assert property (p_nmi_copro) else $error("nmi low with coprocessor on");
	property p_nmi_idle;
		(warm_q == 3'h7 && copro_int_n && parity_n && channel_check_n) [*5] |-> !nmi_q;
	endproperty
	a_nmi_idle: assert property (p_nmi_idle) else $error("nmi high with no source");
	property p_nmi_rise;
		warm_q == 3'h7 && $rose(nmi_q) |-> !$past(copro_int_n & parity_n & channel_check_n, 3);
	endproperty
	a_nmi_rise: assert property (p_nmi_rise) else $error("nmi rose without a source");
	property p_rearm_onehot; $onehot0(rearm_q); endproperty
	a_rearm_onehot: assert property (p_rearm_onehot) else $error("two rearm strobes");
	property p_rearm_pulse; |rearm_q |=> rearm_q == 6'h00; endproperty
	a_rearm_pulse: assert property (p_rearm_pulse) else $error("rearm strobe too long");
	property p_rearm_b; |rearm_q |-> $rose(bvalid) && bresp == `RESP_OKAY; endproperty
	a_rearm_b: assert property (p_rearm_b) else $error("rearm not with write answer");
	property p_b_block; bvalid |-> !awready && !wready; endproperty
	a_b_block: assert property (p_b_block) else $error("write taken during answer");
	property p_r_block; rvalid |-> !arready; endproperty
	a_r_block: assert property (p_r_block) else $error("read taken during answer");
endmodule
bind shared_irq_logic shared_irq_logic_assertions u_shared_irq_logic_assertions (.aclk,
	.aresetn, .awready, .wready, .arready, .bvalid, .bresp, .rvalid, .copro_int_n,
	.parity_n, .channel_check_n, .nmi_q, .rearm_q);

// file: tb/shared_adapter_model.sv
// Purpose: One expansion adapter sharing a request line by pulsing it low.
// Assumes: Line is wire-ANDed with a pull-up outside this model.
// Notes:   A pulse lasts three cycles, longer than the one the synchroniser needs.
`timescale 1ns/100ps
// ==========================================================================
// Adapter
module shared_adapter_model #(
	parameter LEVEL = 7
) (
	// Clock and reset
	input wire       aclk,
	input wire       aresetn,
	// Software enable and internal condition
	input wire       enable,
	input wire       cond,
	// Shared line and rearm strobes
	input wire       line_n,
	input wire [7:2] rearm,
	output reg       drive_n,
	output reg       mine
);
	reg       armed;
	reg [1:0] cnt;
	always @(posedge aclk) begin
		if (!aresetn) begin
			drive_n <= 1'b1;
			armed   <= 1'b1;
			cnt     <= 2'h0;
			mine    <= 1'b0;
		end else if (cnt != 2'h0) begin
			cnt <= cnt - 2'h1;
			if (cnt == 2'h1) drive_n <= 1'b1;
		end else if (rearm[LEVEL]) begin
			armed <= 1'b1;
		end else if (!line_n) begin
			armed <= 1'b0;
		end else if (armed && enable && cond) begin
			drive_n <= 1'b0;
			cnt     <= 2'h3;
			mine    <= 1'b1;
			armed   <= 1'b0;
		end else if (!cond) begin
			mine <= 1'b0;
		end
	end
endmodule

// file: tb/shared_irq_logic_tb.sv
// Purpose: Drives registers, board sources, two sharing adapters and NMI inputs.
// Assumes: Request latency of a few cycles after a line returns high.
// Notes:   Waits after requests are fixed; bus waits are bounded loops.
`timescale 1ns/100ps
`include "shared_irq_map.vh"
module shared_irq_logic_tb;
	reg aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	reg [7:0] awaddr = 0, araddr = 0;
	reg [31:0] wdata = 0, rd_d;
	reg [3:0] wstrb = 4'hf;
	reg [1:0] rs, bs;
	reg tmr = 0, kb = 0, pt = 0, vid = 0, ser = 0, par = 0, cop = 1, prt = 1, chkn = 1;
	reg en = 0, ca = 0, cb = 0;
	wire awready, wready, bvalid, arready, rvalid, int_req_q, nmi_q, da, db, ma, mb;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [2:0] int_vec_q;
	wire [7:2] rearm_q;
	wire [7:2] bus_irq_n = {da & db, 5'h1f};
	integer miscompares = 0, check_count = 0, i, n;
	reg [5:0] nt [0:4];
	reg [2:0] lv [0:4];
	always #2 aclk = ~aclk;
	shared_irq_logic u_shared_irq_logic (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .timer0_out(tmr), .keyboard_req(kb), .pointing_req(pt),
		.video_req(vid), .serial_req(ser), .parallel_req(par), .bus_irq_n(bus_irq_n),
		.copro_int_n(cop), .parity_n(prt), .channel_check_n(chkn), .int_req_q(int_req_q),
		.int_vec_q(int_vec_q), .nmi_q(nmi_q), .rearm_q(rearm_q));
	shared_adapter_model #(.LEVEL(7)) u_a (.aclk(aclk), .aresetn(aresetn), .enable(en),
		.cond(ca), .line_n(bus_irq_n[7]), .rearm(rearm_q), .drive_n(da), .mine(ma));
	shared_adapter_model #(.LEVEL(7)) u_b (.aclk(aclk), .aresetn(aresetn), .enable(en),
		.cond(cb), .line_n(bus_irq_n[7]), .rearm(rearm_q), .drive_n(db), .mine(mb));
	task tally_and_finish;
		begin
			$display("checks %0d mismatches %0d", check_count, miscompares);
			if (miscompares == 0 && check_count > 0) $display("Testbench passed");
			else $display("Testbench failed");
			$finish;
		end
	endtask
	task chk(input string nm, input [31:0] e, input [31:0] g);
		begin
			check_count = check_count + 1;
			if (g !== e) begin
				miscompares = miscompares + 1;
				$display("wrong value %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task cyc(input integer k);
		repeat (k) @(posedge aclk);
	endtask
	task wr(input [7:0] a, input [31:0] d);
		begin
			awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
			// Always wait one edge: an answer seen at entry belongs to the previous transfer.
			for (n = 0; n < 50 && (n == 0 || !(bready && bvalid)); n = n + 1) begin
				@(posedge aclk);
				if (awready) awvalid <= 0;
				if (wready) wvalid <= 0;
				bs = bresp;
			end
			if (n == 50) begin miscompares = miscompares + 1; tally_and_finish; end
		end
	endtask
	task rd(input [7:0] a);
		begin
			araddr <= a; arvalid <= 1; rready <= 1;
			for (n = 0; n < 50 && (n == 0 || !(rready && rvalid)); n = n + 1) begin
				@(posedge aclk);
				if (arready) arvalid <= 0;
				rd_d = rdata; rs = rresp;
			end
			if (n == 50) begin miscompares = miscompares + 1; tally_and_finish; end
		end
	endtask
	initial begin
		nt[0] = 6'h38; nt[1] = 6'h29; nt[2] = 6'h1d; nt[3] = 6'h2c; nt[4] = 6'h33;
		lv[0] = 0; lv[1] = 1; lv[2] = 2; lv[3] = 4; lv[4] = 7;
		cyc(10);
		aresetn <= 1;
		cyc(2);
		rd(`OFS_MASK); chk("mask", 32'hff, rd_d);
		rd(`OFS_SYSCTL); chk("sysctl", 32'h0, rd_d);
		rd(`OFS_PENDING); chk("pending", 32'h0, rd_d);
		rd(`OFS_REARM); chk("rearm base", 32'h2f0, rd_d);
		rd(8'h40); chk("unmapped", `RESP_SLVERR, rs);
		wr(8'h40, 32'h0);
		chk("unmapped write", `RESP_SLVERR, bs);
		$display("test reset done");
		wr(`OFS_MASK, 32'h0);
		chk("mask write", `RESP_OKAY, bs);
		{tmr, kb, pt, vid, ser, par} <= 6'h3f;
		cyc(4);
		{tmr, kb, pt, vid, ser, par} <= 6'h00;
		cyc(8);
		rd(`OFS_PENDING); chk("pending", 32'h97, rd_d);
		wr(`OFS_MASK, 32'h1);
		cyc(2);
		chk("masked vector", 1, int_vec_q);
		wr(`OFS_MASK, 32'h0);
		cyc(2);
		for (i = 0; i < 5; i = i + 1) begin
			chk("int_req", 1, int_req_q);
			chk("int_vec", lv[i], int_vec_q);
			rd(`OFS_VECTOR); chk("vector", {24'h0, 5'h10, lv[i]}, rd_d);
			wr(`OFS_EOI, 32'h1);
			cyc(2);
		end
		$display("test priority done");
		en <= 1; ca <= 1;
		cyc(1);
		cb <= 1;
		cyc(12);
		rd(`OFS_PENDING); chk("pending", 32'h80, rd_d);
		chk("owner", 2'h2, {ma, mb});
		rd(`OFS_VECTOR); chk("vector", 32'h87, rd_d);
		ca <= 0;
		wr(`OFS_REARM, 32'h6); cyc(12);
		rd(`OFS_PENDING); chk("pending", 32'h0, rd_d);
		wr(`OFS_REARM, 32'h7); cyc(12);
		rd(`OFS_PENDING); chk("pending", 32'h80, rd_d);
		chk("owner", 2'h1, {ma, mb});
		$display("test sharing done");
		for (i = 0; i < 5; i = i + 1) begin
			wr(`OFS_SYSCTL, {26'h0, nt[i][5:4], 4'h0});
			{cop, prt, chkn} <= nt[i][3:1];
			cyc(8);
			chk("nmi", nt[i][0], nmi_q);
		end
		$display("test nmi done");
		tally_and_finish;
	end
endmodule
